// file: verilog/pmd_regs.svh
`ifndef PMD_REGS_SVH
`define PMD_REGS_SVH

`define PMD_NREG 6
`define PMD_ADR_W 8
`define PMD_OFS_CTRL0 8'h00
`define PMD_OFS_STRIDE 8'h04
`define PMD_OFS_STATUS 8'h18
`define PMD_RESET 8'h00

`define PMD_IMPL0 8'hc7
`define PMD_IMPL1 8'h87
`define PMD_IMPL2 8'h67
`define PMD_IMPL3 8'h3f
`define PMD_IMPL4 8'h51
`define PMD_IMPL5 8'h1e

`define PMD_IDX_PROGMEM 2
`define PMD_IDX_SYSCLK 7
`define PMD_IDX_VREF 6
`define PMD_IDX_EDGE_IRQ 0

`define PMD_ST_BIT_SETTLING 0
`define PMD_ST_BIT_MEM_READY 1

`define PMD_CLK_MHZ 25
`define PMD_INSTR_NS 160
`define PMD_NVM_WAKE_NS 1000
`define PMD_INSTR_CYC ((`PMD_INSTR_NS * `PMD_CLK_MHZ + 999) / 1000)
`define PMD_NVM_CYC ((`PMD_NVM_WAKE_NS * `PMD_CLK_MHZ + 999) / 1000)

`endif

// file: verilog/pmd_pkg.sv
`default_nettype none
package pmd_pkg;
	typedef enum logic [2:0] {
		PMD_ST_ON = 3'b001,
		PMD_ST_OFF = 3'b010,
		PMD_ST_WAKE = 3'b100
	} pmd_state_t;
	typedef logic [7:0] pmd_byte_t;
endpackage
`default_nettype wire

// file: verilog/pmd_gate.sv
`timescale 1ns/1ps
`default_nettype none
module pmd_gate #(
	parameter int WAKE_CYC = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic off,
	output logic clk_en_q,
	output logic rst_hold_q,
	output logic block_q
);
	localparam int CW = $clog2(WAKE_CYC + 1);
	pmd_pkg::pmd_state_t st_q, st_d;
	logic [CW-1:0] cnt_q, cnt_d;

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		unique case (st_q)
			pmd_pkg::PMD_ST_ON:
			begin
				if (off)
					st_d = pmd_pkg::PMD_ST_OFF;
			end
			pmd_pkg::PMD_ST_OFF:
			begin
				if (!off)
				begin
					st_d = pmd_pkg::PMD_ST_WAKE;
					cnt_d = CW'(WAKE_CYC - 1);
				end
			end
			pmd_pkg::PMD_ST_WAKE:
			begin
				if (off)
					st_d = pmd_pkg::PMD_ST_OFF;
				else if (cnt_q == '0)
					st_d = pmd_pkg::PMD_ST_ON;
				else
					cnt_d = cnt_q - 1'b1;
			end
			default:
				st_d = pmd_pkg::PMD_ST_ON;
		endcase
	end

	// The enable feeds a latch-based gate cell, so changing it only on
	// a clock edge keeps the gated clock free of runt pulses.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= pmd_pkg::PMD_ST_ON;
			cnt_q <= '0;
			clk_en_q <= 1'b1;
			rst_hold_q <= 1'b0;
			block_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			clk_en_q <= (st_d != pmd_pkg::PMD_ST_OFF);
			rst_hold_q <= (st_d != pmd_pkg::PMD_ST_ON);
			block_q <= (st_d != pmd_pkg::PMD_ST_ON);
		end
	end
endmodule
`default_nettype wire

// file: verilog/pmd_top.sv
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "pmd_regs.svh"
module pmd_top #(
	parameter int INSTR_CYC = `PMD_INSTR_CYC,
	parameter int NVM_CYC = `PMD_NVM_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [47:0] periph_clk_en,
	output logic [47:0] periph_rst_hold,
	output logic [47:0] periph_access_block,
	output logic [47:0] pps_disable,
	input wire logic sfr_req,
	input wire logic sfr_we,
	input wire logic [5:0] sfr_idx,
	input wire logic [7:0] sfr_rdata,
	output logic sfr_req_q,
	output logic sfr_we_q,
	output logic [7:0] sfr_rdata_q
);
	localparam int NREG = `PMD_NREG;
	localparam logic [47:0] IMPL = {`PMD_IMPL5,
		`PMD_IMPL4,
		`PMD_IMPL3,
		`PMD_IMPL2,
		`PMD_IMPL1,
		`PMD_IMPL0};

	// Word index of a byte address relative to the first control register.
	function automatic logic [5:0] word_index(input logic [7:0] adr);
		logic [7:0] rel;
		rel = adr - `PMD_OFS_CTRL0;
		word_index = rel[7:2];
	endfunction

	logic [NREG-1:0][7:0] ctrl_q;
	logic [47:0] disable_q;
	logic [47:0] gate_block;
	logic [1:0] status_q;
	logic wb_req;
	logic wb_wr;
	logic [5:0] wb_idx;
	logic idx_is_ctrl;
	logic idx_is_status;
	logic [7:0] rd_byte;
	logic sfr_blocked;
	logic settling;

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes land at the edge where the master sees ack, so a cycle that
	// is abandoned before then leaves the registers untouched.
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
		wb_sel_i[0];
	assign wb_idx = word_index(wb_adr_i);
	assign idx_is_ctrl = (wb_adr_i[1:0] == 2'h0) &&
		(wb_idx < 6'(NREG));
	assign idx_is_status = (wb_adr_i == `PMD_OFS_STATUS);
	assign disable_q = ctrl_q;

	// Control registers: unimplemented bits are masked off on the way in,
	// so they read back as zero without a separate read mask.
	genvar r;
	generate
		for (r = 0; r < NREG; r++)
		begin : g_reg
			logic hit;
			assign hit = wb_wr && idx_is_ctrl && (wb_idx == 6'(r));
			always_ff @(posedge sys_clk or posedge rst)
			begin
				if (rst)
					ctrl_q[r] <= `PMD_RESET;
				else if (hit)
					ctrl_q[r] <= wb_dat_i[7:0] & IMPL[r*8 +: 8];
			end
		end
	endgenerate

	assign rd_byte = idx_is_ctrl ? ctrl_q[wb_idx[2:0]] :
		idx_is_status ? {6'h00, status_q} : 8'h00;

	// Single-cycle answer: ack rises the edge after the strobe and falls
	// one cycle later, so a held strobe starts a new access every second cycle.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i)
				wb_dat_o <= {24'h00_0000, rd_byte};
		end
	end

	// One gate per bit; the memory unit gets the longer wake time because
	// its data is not usable straight after the clock returns.
	genvar i;
	generate
		for (i = 0; i < 48; i++)
		begin : g_gate
			pmd_gate #(
				.WAKE_CYC((i == `PMD_IDX_PROGMEM) ? NVM_CYC : INSTR_CYC)
			) u_gate (
				.sys_clk(sys_clk),
				.rst(rst),
				.off(disable_q[i]),
				.clk_en_q(periph_clk_en[i]),
				.rst_hold_q(periph_rst_hold[i]),
				.block_q(gate_block[i])
			);
		end
	endgenerate

	assign periph_access_block = gate_block;
	assign pps_disable = gate_block;

	assign settling = |(periph_rst_hold & ~disable_q);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			status_q <= 2'h2;
		else
		begin
			status_q[`PMD_ST_BIT_SETTLING] <= settling;
			status_q[`PMD_ST_BIT_MEM_READY] <=
				!gate_block[`PMD_IDX_PROGMEM];
		end
	end

	// Peripheral register access stage. A blocked target sees no write
	// strobe and the core sees zero; this costs one cycle of latency on
	// every register access, traded for outputs straight from flops.
	assign sfr_blocked = gate_block[sfr_idx];

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sfr_req_q <= 1'b0;
			sfr_we_q <= 1'b0;
			sfr_rdata_q <= 8'h00;
		end
		else
		begin
			sfr_req_q <= sfr_req && !sfr_blocked;
			sfr_we_q <= sfr_req && sfr_we && !sfr_blocked;
			if (sfr_req && !sfr_we)
				sfr_rdata_q <= sfr_blocked ? 8'h00 : sfr_rdata;
		end
	end

	// Memory unit blocking shares the same path: a program memory or
	// indirect read with the memory unit off comes back as zero.
	property p_mem_zero;
		@(posedge sys_clk) disable iff (rst)
		sfr_req && !sfr_we && (sfr_idx == 6'(`PMD_IDX_PROGMEM)) &&
			gate_block[`PMD_IDX_PROGMEM] |=> (sfr_rdata_q == 8'h00);
	endproperty
	a_mem_zero: assert property (p_mem_zero)
		else $error("memory read not zero while memory unit off");

	property p_rst_zero;
		@(posedge sys_clk)
		$fell(rst) |-> (disable_q == 48'h0000_0000_0000) &&
			(periph_clk_en == {48{1'b1}});
	endproperty
	a_rst_zero: assert property (p_rst_zero)
		else $error("peripherals not all enabled after reset");

	property p_off_gates;
		@(posedge sys_clk) disable iff (rst)
		1'b1 |-> ((periph_clk_en & $past(disable_q)) == 48'h0000_0000_0000);
	endproperty
	a_off_gates: assert property (p_off_gates)
		else $error("clock still enabled one cycle after disable");

	property p_off_reset;
		@(posedge sys_clk) disable iff (rst)
		1'b1 |-> ((~periph_rst_hold & $past(disable_q)) ==
			48'h0000_0000_0000);
	endproperty
	a_off_reset: assert property (p_off_reset)
		else $error("disabled peripheral not held in reset");

	property p_wr_block;
		@(posedge sys_clk) disable iff (rst)
		sfr_req && sfr_we && gate_block[sfr_idx] |=> !sfr_we_q;
	endproperty
	a_wr_block: assert property (p_wr_block)
		else $error("write passed to a disabled peripheral");

	property p_rd_zero;
		@(posedge sys_clk) disable iff (rst)
		sfr_req && !sfr_we && gate_block[sfr_idx] |=>
			(sfr_rdata_q == 8'h00);
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("read of disabled peripheral not zero");

	sequence s_vref_parked;
		periph_rst_hold[`PMD_IDX_VREF] && !periph_clk_en[`PMD_IDX_VREF] &&
			!disable_q[`PMD_IDX_VREF];
	endsequence
	property p_wake;
		@(posedge sys_clk) disable iff (rst)
		s_vref_parked |=> periph_clk_en[`PMD_IDX_VREF] &&
			periph_rst_hold[`PMD_IDX_VREF];
	endproperty
	a_wake: assert property (p_wake)
		else $error("re-enabled peripheral did not wake in reset");

	property p_nvm_wake;
		@(posedge sys_clk) disable iff (rst)
		$rose(periph_clk_en[`PMD_IDX_PROGMEM]) |->
			(periph_rst_hold[`PMD_IDX_PROGMEM] ||
			disable_q[`PMD_IDX_PROGMEM]) [*8];
	endproperty
	a_nvm_wake: assert property (p_nvm_wake)
		else $error("memory unit released too soon after wake");

	property p_sysclk;
		@(posedge sys_clk) disable iff (rst)
		disable_q[`PMD_IDX_SYSCLK] |=> !periph_clk_en[`PMD_IDX_SYSCLK];
	endproperty
	a_sysclk: assert property (p_sysclk)
		else $error("system clock network still enabled");

	property p_unimpl;
		@(posedge sys_clk) disable iff (rst)
		1'b1 |-> ((disable_q & ~IMPL) == 48'h0000_0000_0000);
	endproperty
	a_unimpl: assert property (p_unimpl)
		else $error("unimplemented control bit set");

	property p_glitch;
		@(posedge sys_clk) disable iff (rst)
		$rose(periph_clk_en[`PMD_IDX_EDGE_IRQ]) |->
			!$past(disable_q[`PMD_IDX_EDGE_IRQ]);
	endproperty
	a_glitch: assert property (p_glitch)
		else $error("clock enable rose while disable bit set");

	property p_ack;
		@(posedge sys_clk) disable iff (rst)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("bus answer not a single cycle pulse");

	property p_status;
		@(posedge sys_clk) disable iff (rst)
		gate_block[`PMD_IDX_PROGMEM] |=>
			!status_q[`PMD_ST_BIT_MEM_READY];
	endproperty
	a_status: assert property (p_status)
		else $error("memory ready shown while memory unit blocked");

	property p_pps_off;
		@(posedge sys_clk) disable iff (rst)
		1'b1 |-> ((~pps_disable & $past(disable_q)) ==
			48'h0000_0000_0000);
	endproperty
	a_pps_off: assert property (p_pps_off)
		else $error("pin routing still enabled for a disabled peripheral");

	property p_clk_hold;
		@(posedge sys_clk) disable iff (rst)
		1'b1 |-> ((~periph_clk_en & ~periph_rst_hold) ==
			48'h0000_0000_0000);
	endproperty
	a_clk_hold: assert property (p_clk_hold)
		else $error("stopped peripheral not held in reset");

	property p_wake_block;
		@(posedge sys_clk) disable iff (rst)
		$rose(periph_clk_en[`PMD_IDX_VREF]) |->
			periph_rst_hold[`PMD_IDX_VREF] &&
			periph_access_block[`PMD_IDX_VREF];
	endproperty
	a_wake_block: assert property (p_wake_block)
		else $error("re-enabled peripheral released before its wake time");

	property p_sfr_pass;
		@(posedge sys_clk) disable iff (rst)
		sfr_req && !gate_block[sfr_idx] |=> sfr_req_q;
	endproperty
	a_sfr_pass: assert property (p_sfr_pass)
		else $error("request to an enabled peripheral was dropped");

	property p_wb_hi;
		@(posedge sys_clk) disable iff (rst)
		wb_ack_o |-> (wb_dat_o[31:8] == 24'h00_0000);
	endproperty
	a_wb_hi: assert property (p_wb_hi)
		else $error("upper read data lanes not zero");

	property p_ack_idle;
		@(posedge sys_clk) disable iff (rst)
		!wb_cyc_i |=> !wb_ack_o;
	endproperty
	a_ack_idle: assert property (p_ack_idle)
		else $error("bus answer without a cycle");

	property p_cov_cycle;
		@(posedge sys_clk) disable iff (rst)
		disable_q[`PMD_IDX_VREF] ##1 !disable_q[`PMD_IDX_VREF] ##[1:20]
			!periph_rst_hold[`PMD_IDX_VREF];
	endproperty
	c_cov_cycle: cover property (p_cov_cycle);

	property p_cov_wr_block;
		@(posedge sys_clk) disable iff (rst)
		sfr_req && sfr_we && gate_block[sfr_idx];
	endproperty
	c_cov_wr_block: cover property (p_cov_wr_block);

	property p_cov_nvm;
		@(posedge sys_clk) disable iff (rst)
		$rose(status_q[`PMD_ST_BIT_MEM_READY]);
	endproperty
	c_cov_nvm: cover property (p_cov_nvm);

	property p_cov_sysclk;
		@(posedge sys_clk) disable iff (rst)
		$fell(periph_clk_en[`PMD_IDX_SYSCLK]);
	endproperty
	c_cov_sysclk: cover property (p_cov_sysclk);

	property p_cov_rd_block;
		@(posedge sys_clk) disable iff (rst)
		sfr_req && !sfr_we && gate_block[sfr_idx];
	endproperty
	c_cov_rd_block: cover property (p_cov_rd_block);
endmodule
`default_nettype wire

// file: verif/pmd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pmd_top_tb;
	localparam logic [47:0] impl = 48'h1e513f6787c7;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic sfr_req = 1'b0;
	logic sfr_we = 1'b0;
	logic [5:0] sfr_idx = 6'h00;
	logic [7:0] sfr_rdata = 8'h00;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [47:0] clk_en, hold, blk, pin_select_routing;
	logic req_q, we_q;
	logic [7:0] rd_q8;
	int n_fail = 0;
	int n_tests = 0;
	int seed = 15;
	logic [7:0] exp_q[$];
	logic [47:0] model;
	pmd_top pmd_top_i (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .periph_clk_en(clk_en), .periph_rst_hold(hold),
		.periph_access_block(blk), .pps_disable(pin_select_routing), .sfr_req(sfr_req),
		.sfr_we(sfr_we), .sfr_idx(sfr_idx), .sfr_rdata(sfr_rdata),
		.sfr_req_q(req_q), .sfr_we_q(we_q), .sfr_rdata_q(rd_q8));
	always #20 sys_clk = ~sys_clk;
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk48(string nm, logic [47:0] e, logic [47:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
		chk48(nm, {40'h0, e}, {40'h0, g});
	endtask
	// Read data is judged at the ack edge, oldest expectation first.
	always @(posedge sys_clk)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
		begin
			if (exp_q.size() == 0)
				chk8("read_ack", 8'h00, 8'hff);
			else
				chk48("read_data", {40'h0, exp_q.pop_front()}, {16'h0, wb_dat_o});
		end
	task automatic xfer(logic we, logic [7:0] adr, logic [7:0] d, logic [3:0] s);
		int n;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= s;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 16);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1)
		begin
			n_fail++;
			report_and_stop();
		end
		@(posedge sys_clk);
	endtask
	task automatic wr(logic [7:0] adr, logic [7:0] d);
		xfer(1'b1, adr, d, 4'h1);
	endtask
	task automatic rd(logic [7:0] adr, logic [7:0] e);
		exp_q.push_back(e);
		xfer(1'b0, adr, 8'h00, 4'hf);
	endtask
	// Blocked reads must come back as zero, not as the stale peripheral data.
	task automatic special_function_register(logic we, logic [5:0] idx, logic [7:0] d, logic pass);
		@(posedge sys_clk);
		sfr_req <= 1'b1;
		sfr_we <= we;
		sfr_idx <= idx;
		sfr_rdata <= d;
		@(posedge sys_clk);
		sfr_req <= 1'b0;
		#1;
		chk8("sfr_req_q", {7'h0, pass}, {7'h0, req_q});
		chk8("sfr_we_q", {7'h0, pass & we}, {7'h0, we_q});
		if (!we)
			chk8("sfr_rdata_q", pass ? d : 8'h00, rd_q8);
	endtask
	initial
	begin
		logic [31:0] v;
		int r;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk48("clk_en", {48{1'b1}}, clk_en);
		chk48("rst_hold", 48'h0, hold);
		for (int i = 0; i < 6; i++)
			rd(8'(i * 4), 8'h00);
		rd(8'h18, 8'h02);
		$display("test reset done");
		for (int i = 0; i < 6; i++)
		begin
			wr(8'(i * 4), 8'hff);
			rd(8'(i * 4), impl[i * 8 +: 8]);
		end
		#1;
		chk48("clk_en", ~impl, clk_en);
		chk48("rst_hold", impl, hold);
		chk48("block", impl, blk);
		chk48("pps", impl, pin_select_routing);
		wr(8'h1c, 8'hff);
		rd(8'h1c, 8'h00);
		special_function_register(1'b0, 6'd6, 8'h55, 1'b0);
		special_function_register(1'b1, 6'd2, 8'haa, 1'b0);
		special_function_register(1'b0, 6'd2, 8'h77, 1'b0);
		wr(8'h18, 8'hff);
		rd(8'h18, 8'h00);
		xfer(1'b1, 8'h04, 8'h00, 4'he);
		rd(8'h04, 8'h87);
		$display("test disable done");
		wr(8'h00, 8'h00);
		#1;
		chk8("clk_en0", 8'hff, clk_en[7:0]);
		chk8("hold0", 8'hc7, hold[7:0]);
		special_function_register(1'b0, 6'd6, 8'h55, 1'b0);
		rd(8'h18, 8'h01);
		repeat (4) @(posedge sys_clk);
		#1;
		chk8("hold0", 8'h04, hold[7:0]);
		repeat (20) @(posedge sys_clk);
		#1;
		chk8("hold0", 8'h00, hold[7:0]);
		rd(8'h18, 8'h02);
		special_function_register(1'b0, 6'd6, 8'h5a, 1'b1);
		special_function_register(1'b1, 6'd2, 8'h3c, 1'b1);
		$display("test wake done");
		// Unimplemented bits never gate anything, so they stay enabled.
		model = impl & ~48'hff;
		for (int i = 0; i < 12; i++)
		begin
			v = $random(seed);
			r = v[2:0] % 6;
			wr(8'(r * 4), v[15:8]);
			model[r * 8 +: 8] = v[15:8] & impl[r * 8 +: 8];
			#1;
			chk48("clk_en", ~model, clk_en);
			rd(8'(r * 4), model[r * 8 +: 8]);
		end
		repeat (3) @(posedge sys_clk);
		chk8("pending_reads", 8'h00, 8'(exp_q.size()));
		$display("test random done");
		// A reset in mid-run must drop every disable bit set so far.
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk48("clk_en", {48{1'b1}}, clk_en);
		chk48("block", 48'h0, blk);
		rd(8'h04, 8'h00);
		$display("test reset again done");
		report_and_stop();
	end
endmodule
`default_nettype wire
